// >>> rtl/tsac_ctrl.v
// Temperature sensor control: two-wire slave, registers, alert, APB
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "tsac_defines.vh"
// Summary of operation
// RULE1 - Master code byte precedes any high-speed transfer
// RULE2 - Master code unacknowledged, filters go high-speed
// RULE3 - High-speed ends at STOP, filters back fast
// RULE4 - Clock low too long resets serial interface
// RULE5 - After timeout release data, wait for START
// RULE6 - Master keeps clock fast enough avoiding timeout
// RULE7 - Detect START and STOP while clock high
// RULE8 - Any byte count; MSB-only writes allowed
// RULE9 - Receiver drives ninth-bit acknowledge low
// RULE10 - Master not-acknowledge ends device data drive
// RULE11 - Continuous conversions overwrite the temperature register
// RULE12 - Rate bits select the conversion period
// RULE13 - One conversion per period, then idle
// RULE14 - Conversion starts right after any reset
// RULE15 - Extended bit selects 12- or 13-bit format
// RULE16 - One-shot conversion from shutdown, status bit
// RULE17 - Thermostat bit picks comparator or interrupt
// RULE18 - Comparator: set at upper, clear below lower
// RULE19 - Interrupt: set on fault, clear on read
// RULE20 - Pointer low bits select register, reset zero
// RULE21 - Fault queue needs 1, 2, 4, 6 faults
// RULE22 - Polarity bit sets alert active level
// RULE23 - Shutdown after current conversion completes
// RULE24 - Compare and count once per completed conversion
module tsac_ctrl #(
  parameter [31:0] TIMEOUT_CYC = `TSAC_TIMEOUT_MS * `TSAC_CLK_KHZ,
  parameter [31:0] PER0_CYC = `TSAC_PER0_MS * `TSAC_CLK_KHZ,
  parameter [31:0] PER1_CYC = `TSAC_PER1_MS * `TSAC_CLK_KHZ,
  parameter [31:0] PER2_CYC = `TSAC_PER2_MS * `TSAC_CLK_KHZ,
  parameter [31:0] PER3_CYC = `TSAC_PER3_MS * `TSAC_CLK_KHZ
) (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rst,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Two-wire bus pins
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe,
  output wire hsMode,
  // Address select, static strap on the same clock
  input wire [1:0] devAddrSel,
  // Converter model
  input wire convDone,
  input wire [12:0] convResult,
  output wire convStart,
  output wire converting,
  // Alert pin level
  output wire alertOut
);
  localparam [2:0] I_IDLE = 3'd0;
  localparam [2:0] I_RX = 3'd1;
  localparam [2:0] I_RXACK = 3'd2;
  localparam [2:0] I_TX = 3'd3;
  localparam [2:0] I_TXACK = 3'd4;

  wire sclS;
  wire sdaS;
  reg sclD_ff;
  reg sdaD_ff;
  reg [2:0] i2cState_ff;
  reg [2:0] bitCnt_ff;
  reg [7:0] shift_ff;
  reg [2:0] byteIdx_ff;
  reg rw_ff;
  reg genCall_ff;
  reg ackPhase_ff;
  reg sdaOe_ff;
  reg hsMode_ff;
  reg busy_ff;
  reg txSel_ff;
  reg [1:0] pointer_ff;
  reg [31:0] toCnt_ff;
  reg i2cWrHi_ff;
  reg i2cWrLo_ff;
  reg [7:0] i2cWrData_ff;
  reg genReset_ff;
  reg i2cTempRd_ff;
  reg [15:0] temp_ff;
  reg [15:0] tLow_ff;
  reg [15:0] tHigh_ff;
  reg [1:0] fault_ff;
  reg pol_ff;
  reg tm_ff;
  reg sd_ff;
  reg [1:0] rate_ff;
  reg em_ff;
  reg osDone_ff;
  reg oneShotReq_ff;
  reg [2:0] hiCnt_ff;
  reg [2:0] gtCnt_ff;
  reg [2:0] loCnt_ff;
  reg compAct_ff;
  reg intAct_ff;
  reg alertOut_ff;
  reg [31:0] prdata_ff;

  // Pin inputs pass two flip-flops before any logic reads them
  tsac_sync2 #(.RESET_VAL(1'b1)) u_sync_scl (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .asyncIn(sclIn),
    .syncOut(sclS)
  );
  tsac_sync2 #(.RESET_VAL(1'b1)) u_sync_sda (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .asyncIn(sdaIn),
    .syncOut(sdaS)
  );

  // Previous sampled levels for edge and condition detection
  always @(posedge sys_clk) begin
    if (rst) begin
      sclD_ff <= 1'b1;
      sdaD_ff <= 1'b1;
    end else if (ce) begin
      sclD_ff <= sclS;
      sdaD_ff <= sdaS;
    end
  end

  // Bus edges and conditions; data moving while clock high is framing
  wire sclRise = sclS && !sclD_ff;
  wire sclFall = !sclS && sclD_ff;
  wire busStart = sclS && sclD_ff && sdaD_ff && !sdaS; // [RULE7]
  wire busStop = sclS && sclD_ff && !sdaD_ff && sdaS; // [RULE7]
  wire [7:0] rxByte = {shift_ff[6:0], sdaS};
  wire toExpired = busy_ff && (toCnt_ff == TIMEOUT_CYC - 32'h1);

  // Register contents as seen by either bus
  function [15:0] regVal;
    input [1:0] idx;
    begin
      case (idx)
        `TSAC_PTR_TEMP: regVal = temp_ff;
        `TSAC_PTR_CFG: regVal = {osDone_ff & ~converting, `TSAC_RES_BITS, fault_ff, pol_ff,
          tm_ff, sd_ff, rate_ff, compAct_ff ? pol_ff : ~pol_ff, em_ff, 4'h0}; // [RULE16]
        `TSAC_PTR_TLOW: regVal = tLow_ff;
        default: regVal = tHigh_ff;
      endcase
    end
  endfunction

  wire [15:0] ptrWord = regVal(pointer_ff);

  // Two-wire slave state machine
  always @(posedge sys_clk) begin
    if (rst) begin
      i2cState_ff <= I_IDLE;
      bitCnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      byteIdx_ff <= 3'h0;
      rw_ff <= 1'b0;
      genCall_ff <= 1'b0;
      ackPhase_ff <= 1'b0;
      sdaOe_ff <= 1'b0;
      hsMode_ff <= 1'b0;
      busy_ff <= 1'b0;
      txSel_ff <= 1'b0;
      pointer_ff <= `TSAC_PTR_TEMP; // [RULE20]
      toCnt_ff <= 32'h0;
      i2cWrHi_ff <= 1'b0;
      i2cWrLo_ff <= 1'b0;
      i2cWrData_ff <= 8'h00;
      genReset_ff <= 1'b0;
      i2cTempRd_ff <= 1'b0;
    end else if (ce) begin
      i2cWrHi_ff <= 1'b0;
      i2cWrLo_ff <= 1'b0;
      genReset_ff <= 1'b0;
      i2cTempRd_ff <= 1'b0;
      // Stall counter runs while the clock is held low inside a frame
      if (busy_ff && !sclS) begin
        toCnt_ff <= toCnt_ff + 32'h1; // [RULE4] [RULE6]
      end else begin
        toCnt_ff <= 32'h0;
      end
      if (busStart) begin
        i2cState_ff <= I_RX;
        bitCnt_ff <= 3'h0;
        byteIdx_ff <= 3'h0;
        busy_ff <= 1'b1;
        sdaOe_ff <= 1'b0;
        ackPhase_ff <= 1'b0;
      end else if (busStop) begin
        i2cState_ff <= I_IDLE;
        busy_ff <= 1'b0;
        hsMode_ff <= 1'b0; // [RULE3]
        sdaOe_ff <= 1'b0;
      end else if (toExpired) begin
        i2cState_ff <= I_IDLE; // [RULE4] [RULE5]
        busy_ff <= 1'b0;
        hsMode_ff <= 1'b0;
        sdaOe_ff <= 1'b0; // [RULE5]
        toCnt_ff <= 32'h0;
      end else begin
        case (i2cState_ff)
          I_RX: begin
            if (sclRise) begin
              shift_ff <= rxByte;
              bitCnt_ff <= bitCnt_ff + 3'h1;
              if (bitCnt_ff == 3'h7) begin
                i2cState_ff <= I_RXACK;
                ackPhase_ff <= 1'b0;
                i2cWrData_ff <= rxByte;
                case (byteIdx_ff)
                  3'h0: begin
                    if (rxByte[7:3] == `TSAC_MASTER_CODE) begin
                      hsMode_ff <= 1'b1; // [RULE1] [RULE2]
                      i2cState_ff <= I_IDLE; // [RULE2]
                    end else if (rxByte[7:1] == {`TSAC_DEV_ADDR_BASE, devAddrSel}) begin
                      rw_ff <= rxByte[0];
                      genCall_ff <= 1'b0;
                    end else if (rxByte == 8'h00) begin
                      rw_ff <= 1'b0;
                      genCall_ff <= 1'b1;
                    end else begin
                      i2cState_ff <= I_IDLE;
                    end
                  end
                  3'h1: begin
                    if (genCall_ff) begin
                      genReset_ff <= (rxByte == `TSAC_GC_RESET);
                    end else begin
                      pointer_ff <= rxByte[1:0]; // [RULE20]
                    end
                  end
                  3'h2: i2cWrHi_ff <= !genCall_ff; // [RULE8]
                  3'h3: i2cWrLo_ff <= !genCall_ff; // [RULE8]
                  default: i2cWrLo_ff <= 1'b0;
                endcase
              end
            end
          end
          I_RXACK: begin
            if (sclFall) begin
              if (!ackPhase_ff) begin
                sdaOe_ff <= 1'b1; // [RULE9]
                ackPhase_ff <= 1'b1;
              end else begin
                ackPhase_ff <= 1'b0;
                bitCnt_ff <= 3'h0;
                if (byteIdx_ff != 3'h4) begin
                  byteIdx_ff <= byteIdx_ff + 3'h1; // [RULE8]
                end
                if (rw_ff) begin
                  shift_ff <= ptrWord[15:8];
                  sdaOe_ff <= ~ptrWord[15];
                  txSel_ff <= 1'b1;
                  i2cTempRd_ff <= (pointer_ff == `TSAC_PTR_TEMP); // [RULE19]
                  i2cState_ff <= I_TX;
                end else begin
                  sdaOe_ff <= 1'b0;
                  i2cState_ff <= I_RX;
                end
              end
            end
          end
          I_TX: begin
            if (sclFall) begin
              bitCnt_ff <= bitCnt_ff + 3'h1;
              if (bitCnt_ff == 3'h7) begin
                sdaOe_ff <= 1'b0;
                i2cState_ff <= I_TXACK;
              end else begin
                shift_ff <= {shift_ff[6:0], 1'b0};
                sdaOe_ff <= ~shift_ff[6];
              end
            end
          end
          I_TXACK: begin
            if (sclRise && sdaS) begin
              i2cState_ff <= I_IDLE; // [RULE10]
            end else if (sclFall) begin
              bitCnt_ff <= 3'h0;
              shift_ff <= txSel_ff ? ptrWord[7:0] : ptrWord[15:8];
              sdaOe_ff <= txSel_ff ? ~ptrWord[7] : ~ptrWord[15];
              i2cTempRd_ff <= !txSel_ff && (pointer_ff == `TSAC_PTR_TEMP);
              txSel_ff <= ~txSel_ff;
              i2cState_ff <= I_TX;
            end
          end
          default: i2cState_ff <= I_IDLE;
        endcase
      end
    end
  end

  // APB decode; zero wait states, unmapped offsets answer with an error
  wire apbMapped = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
  wire [1:0] apbIdx = paddr[3:2];
  wire apbWr = ce && psel && penable && pwrite && apbMapped;
  wire apbTempRd = ce && psel && penable && !pwrite && apbMapped &&
    (apbIdx == `TSAC_PTR_TEMP);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !apbMapped;

  // Read data captured in the setup cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      prdata_ff <= 32'h0;
    end else if (ce && psel && !penable) begin
      prdata_ff <= (apbMapped && !pwrite) ? {16'h0, regVal(apbIdx)} : 32'h0;
    end
  end
  assign prdata = prdata_ff;

  // Merged write port; APB wins a same-cycle collision
  wire wrHi = apbWr || i2cWrHi_ff;
  wire wrLo = apbWr || i2cWrLo_ff;
  wire [1:0] wrIdx = apbWr ? apbIdx : pointer_ff;
  wire [15:0] wrData = apbWr ? pwdata[15:0] : {i2cWrData_ff, i2cWrData_ff};
  wire tempRead = apbTempRd || i2cTempRd_ff;
  wire regReset = rst || genReset_ff;

  // Result and limits as signed 13-bit values in the active format
  wire [12:0] resVal = em_ff ? convResult : {convResult[11], convResult[11:0]}; // [RULE15]
  wire [12:0] lowVal = em_ff ? tLow_ff[15:3] : {tLow_ff[15], tLow_ff[15:4]}; // [RULE15]
  wire [12:0] highVal = em_ff ? tHigh_ff[15:3] : {tHigh_ff[15], tHigh_ff[15:4]}; // [RULE15]
  wire hiFault = $signed(resVal) >= $signed(highVal); // [RULE18]
  wire gtFault = $signed(resVal) > $signed(highVal); // [RULE19]
  wire loFault = $signed(resVal) < $signed(lowVal);
  wire [2:0] hiNext = hiFault ? ((hiCnt_ff == 3'h7) ? 3'h7 : hiCnt_ff + 3'h1) : 3'h0;
  wire [2:0] gtNext = gtFault ? ((gtCnt_ff == 3'h7) ? 3'h7 : gtCnt_ff + 3'h1) : 3'h0;
  wire [2:0] loNext = loFault ? ((loCnt_ff == 3'h7) ? 3'h7 : loCnt_ff + 3'h1) : 3'h0;
  reg [2:0] faultNeed;

  // Consecutive faults needed before the alert changes
  always @* begin
    case (fault_ff)
      2'h0: faultNeed = 3'h1; // [RULE21]
      2'h1: faultNeed = 3'h2; // [RULE21]
      2'h2: faultNeed = 3'h4; // [RULE21]
      default: faultNeed = 3'h6; // [RULE21]
    endcase
  end

  // Register file, result capture and alert state
  always @(posedge sys_clk) begin
    if (regReset) begin
      temp_ff <= 16'h0;
      tLow_ff <= `TSAC_TLOW_RESET;
      tHigh_ff <= `TSAC_THIGH_RESET;
      fault_ff <= 2'h0;
      pol_ff <= 1'b0; // [RULE22]
      tm_ff <= 1'b0;
      sd_ff <= 1'b0; // [RULE11]
      rate_ff <= `TSAC_RATE_RESET; // [RULE12]
      em_ff <= 1'b0;
      osDone_ff <= 1'b0;
      oneShotReq_ff <= 1'b0;
      hiCnt_ff <= 3'h0;
      gtCnt_ff <= 3'h0;
      loCnt_ff <= 3'h0;
      compAct_ff <= 1'b0;
      intAct_ff <= 1'b0;
    end else if (ce) begin
      oneShotReq_ff <= wrHi && (wrIdx == `TSAC_PTR_CFG) && wrData[`TSAC_CFG_OS] && sd_ff;
      if (wrHi && (wrIdx == `TSAC_PTR_CFG)) begin
        fault_ff <= wrData[`TSAC_CFG_FAULT_HI:`TSAC_CFG_FAULT_LO];
        pol_ff <= wrData[`TSAC_CFG_POL];
        tm_ff <= wrData[`TSAC_CFG_TM]; // [RULE17]
        sd_ff <= wrData[`TSAC_CFG_SD]; // [RULE23]
      end
      if (wrLo && (wrIdx == `TSAC_PTR_CFG)) begin
        rate_ff <= wrData[`TSAC_CFG_RATE_HI:`TSAC_CFG_RATE_LO]; // [RULE12]
        em_ff <= wrData[`TSAC_CFG_EM];
      end
      // Limits update byte by byte
      if (wrHi && (wrIdx == `TSAC_PTR_TLOW)) begin
        tLow_ff[15:8] <= wrData[15:8]; // [RULE8]
      end
      if (wrLo && (wrIdx == `TSAC_PTR_TLOW)) begin
        tLow_ff[7:0] <= wrData[7:0];
      end
      if (wrHi && (wrIdx == `TSAC_PTR_THIGH)) begin
        tHigh_ff[15:8] <= wrData[15:8]; // [RULE8]
      end
      if (wrLo && (wrIdx == `TSAC_PTR_THIGH)) begin
        tHigh_ff[7:0] <= wrData[7:0];
      end
      if (oneShotReq_ff) begin
        osDone_ff <= 1'b0; // [RULE16]
      end
      // One compare and count step per finished conversion
      if (convDone) begin
        temp_ff <= em_ff ? {convResult, 3'h1} : {convResult[11:0], 4'h0}; // [RULE11] [RULE15]
        osDone_ff <= 1'b1; // [RULE16]
        hiCnt_ff <= hiNext; // [RULE24]
        gtCnt_ff <= gtNext;
        loCnt_ff <= loNext;
        if (hiNext >= faultNeed) begin
          compAct_ff <= 1'b1; // [RULE18]
        end else if (loNext >= faultNeed) begin
          compAct_ff <= 1'b0; // [RULE18]
        end
      end
      // Interrupt flag: a new fault wins over a clearing read
      if (convDone && tm_ff && ((gtNext >= faultNeed) || (loNext >= faultNeed))) begin
        intAct_ff <= 1'b1; // [RULE19]
      end else if (tempRead) begin
        intAct_ff <= 1'b0; // [RULE19]
      end
    end
  end

  // Conversion scheduling
  tsac_conv_sched #(
    .PER0_CYC(PER0_CYC),
    .PER1_CYC(PER1_CYC),
    .PER2_CYC(PER2_CYC),
    .PER3_CYC(PER3_CYC)
  ) u_sched (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .restart(genReset_ff),
    .shutdownBit(sd_ff),
    .rateBits(rate_ff),
    .oneShotReq(oneShotReq_ff),
    .convDone(convDone),
    .convStart(convStart),
    .converting(converting)
  );

  // Alert pin with selectable mode and polarity
  always @(posedge sys_clk) begin
    if (rst) begin
      alertOut_ff <= 1'b1;
    end else if (ce) begin
      alertOut_ff <= (tm_ff ? intAct_ff : compAct_ff) ? pol_ff : ~pol_ff; // [RULE17] [RULE22]
    end
  end

  assign alertOut = alertOut_ff;
  assign sdaOut = 1'b0; // Open drain: only ever pulls low
  assign sdaOe = sdaOe_ff;
  assign hsMode = hsMode_ff; // [RULE2]
endmodule

// >>> rtl/tsac_defines.vh
// Shared constants of the temperature sensor control block
`ifndef TSAC_DEFINES_VH
`define TSAC_DEFINES_VH

// APB byte offsets, one aligned word per register
`define TSAC_OFF_TEMP 12'h000
`define TSAC_OFF_CFG 12'h004
`define TSAC_OFF_TLOW 12'h008
`define TSAC_OFF_THIGH 12'h00C

// Pointer select codes
`define TSAC_PTR_TEMP 2'h0
`define TSAC_PTR_CFG 2'h1
`define TSAC_PTR_TLOW 2'h2
`define TSAC_PTR_THIGH 2'h3

// Configuration word field positions
`define TSAC_CFG_OS 15
`define TSAC_CFG_FAULT_HI 12
`define TSAC_CFG_FAULT_LO 11
`define TSAC_CFG_POL 10
`define TSAC_CFG_TM 9
`define TSAC_CFG_SD 8
`define TSAC_CFG_RATE_HI 7
`define TSAC_CFG_RATE_LO 6
`define TSAC_CFG_AL 5
`define TSAC_CFG_EM 4

// Reset values
`define TSAC_RATE_RESET 2'h2
`define TSAC_RES_BITS 2'h3
`define TSAC_TLOW_RESET 16'h4B00
`define TSAC_THIGH_RESET 16'h5000

// Two-wire bus codes
`define TSAC_DEV_ADDR_BASE 5'h12
`define TSAC_MASTER_CODE 5'h01
`define TSAC_GC_RESET 8'h06

// Timing: clock rate, bus-stall timeout and conversion periods
`define TSAC_CLK_KHZ 50000
`define TSAC_TIMEOUT_MS 30
`define TSAC_PER0_MS 4000
`define TSAC_PER1_MS 1000
`define TSAC_PER2_MS 250
`define TSAC_PER3_MS 125

`endif

// >>> rtl/tsac_sync2.v
// Two flip-flop synchroniser for one pin input
`timescale 1ns/1ps
module tsac_sync2 #(
  parameter [0:0] RESET_VAL = 1'b1
) (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rst,
  input wire ce,
  // Level in and synchronised level out
  input wire asyncIn,
  output wire syncOut
);
  reg meta_ff;
  reg sync_ff;

  // First stage feeds only the second stage
  always @(posedge sys_clk) begin
    if (rst) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else if (ce) begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end

  assign syncOut = sync_ff;
endmodule

// >>> rtl/tsac_conv_sched.v
// Conversion scheduler: continuous rate, shutdown and one-shot
`timescale 1ns/1ps
`include "tsac_defines.vh"
module tsac_conv_sched #(
  parameter [31:0] PER0_CYC = `TSAC_PER0_MS * `TSAC_CLK_KHZ,
  parameter [31:0] PER1_CYC = `TSAC_PER1_MS * `TSAC_CLK_KHZ,
  parameter [31:0] PER2_CYC = `TSAC_PER2_MS * `TSAC_CLK_KHZ,
  parameter [31:0] PER3_CYC = `TSAC_PER3_MS * `TSAC_CLK_KHZ
) (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rst,
  input wire ce,
  // Control from the register file
  input wire restart,
  input wire shutdownBit,
  input wire [1:0] rateBits,
  input wire oneShotReq,
  // Converter handshake
  input wire convDone,
  output wire convStart,
  output wire converting
);
  localparam [1:0] S_KICK = 2'd0;
  localparam [1:0] S_CONV = 2'd1;
  localparam [1:0] S_WAIT = 2'd2;
  localparam [1:0] S_SHUT = 2'd3;

  reg [1:0] state_ff;
  reg [31:0] perCnt_ff;
  reg [31:0] period;

  // Rate period selected by the conversion rate bits
  always @* begin
    case (rateBits)
      2'h0: period = PER0_CYC;
      2'h1: period = PER1_CYC;
      2'h2: period = PER2_CYC;
      default: period = PER3_CYC;
    endcase
  end

  // Reset lands in the kick state so a conversion starts at once
  always @(posedge sys_clk) begin
    if (rst || restart) begin
      state_ff <= S_KICK; // [RULE14]
      perCnt_ff <= 32'h0;
    end else if (ce) begin
      case (state_ff)
        S_KICK: begin
          perCnt_ff <= 32'h1; // Kick cycle is the first of the period
          state_ff <= S_CONV;
        end
        S_CONV: begin
          perCnt_ff <= perCnt_ff + 32'h1;
          if (convDone) begin
            state_ff <= shutdownBit ? S_SHUT : S_WAIT; // [RULE23]
          end
        end
        S_WAIT: begin
          perCnt_ff <= perCnt_ff + 32'h1;
          if (shutdownBit) begin
            state_ff <= S_SHUT; // [RULE23]
          end else if (perCnt_ff >= period - 32'h1) begin
            state_ff <= S_KICK; // [RULE11] [RULE12] [RULE13]
          end
        end
        S_SHUT: begin
          if (oneShotReq || !shutdownBit) begin
            state_ff <= S_KICK; // [RULE16]
          end
        end
        default: state_ff <= S_KICK;
      endcase
    end
  end

  assign convStart = (state_ff == S_KICK);
  assign converting = (state_ff == S_KICK) || (state_ff == S_CONV);
endmodule

// >>> testbench/tsac_ctrl_checker.sv
// Port checker of the temperature sensor control block
`timescale 1ns/1ps
module tsac_ctrl_checker #(
  parameter [31:0] TIMEOUT_CYC = 32'hC8
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // APB
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // Two-wire pins
  input wire sclIn,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe,
  input wire hsMode,
  // Converter and alert
  input wire convStart,
  input wire converting,
  input wire alertOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [31:0] lowCnt_ff;
  // Counts clock samples with the bus clock low
  always @(posedge sys_clk) begin
    lowCnt_ff <= (rst || sclIn) ? 32'h0 : lowCnt_ff + 32'h1;
  end
  a_hs_nack: assert property ($rose(hsMode) |-> ##2 !sdaOe [*8])
    else $error("master code acknowledged");
  a_stop_hs: assert property (sclIn && $rose(sdaIn) |-> ##[1:8] !hsMode)
    else $error("high speed kept after stop");
  a_stall_rel: assert property (lowCnt_ff == TIMEOUT_CYC + 32'h8 |-> !sdaOe)
    else $error("data held after clock stall");
  a_ack_stable: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe))
    else $error("data moved while clock high");
  a_open_drain: assert property (!sdaOut)
    else $error("data driven high");
  a_kick_conv: assert property ($fell(rst) |-> converting && alertOut)
    else $error("no conversion after reset");
  a_start_pulse: assert property (convStart |-> converting ##1 !convStart)
    else $error("start not a single pulse");
  a_bad_addr: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access accepted");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("access not answered");
  c_hs: cover property ($rose(hsMode));
  c_err: cover property (pslverr);
  c_alert: cover property ($fell(alertOut));
endmodule

bind tsac_ctrl tsac_ctrl_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .hsMode(hsMode), .convStart(convStart), .converting(converting),
  .alertOut(alertOut));

// >>> testbench/tsac_bus_master.sv
// Two-wire bus master model with a 160 ns bus clock
`timescale 1ns/1ps
module tsac_bus_master (
  // Wire levels
  output logic sclLine,
  output logic sdaLow,
  input wire sdaWire
);
  localparam time Q = 40;
  // Idle bus: both lines released
  initial begin
    sclLine = 1'b1;
    sdaLow = 1'b0;
  end
  // Data falls while clock high
  task automatic busStart;
    #80;
    sdaLow = 1'b1;
    #Q;
    sclLine = 1'b0;
    #Q;
  endtask
  // Data rises while clock high
  task automatic busStop;
    #Q;
    sdaLow = 1'b1;
    #Q;
    sclLine = 1'b1;
    #Q;
    sdaLow = 1'b0;
  endtask
  // One bit, data set late in the low phase after the slave has moved
  task automatic sendBit(input logic v, output logic s);
    #70;
    sdaLow = ~v;
    #10;
    sclLine = 1'b1;
    #Q;
    s = sdaWire;
    #Q;
    sclLine = 1'b0;
  endtask
  // Byte MSB first, then released for acknowledge
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) sendBit(b[i], s);
    sendBit(1'b1, s);
    ack = ~s;
  endtask
endmodule

// >>> testbench/tsac_ctrl_tb.sv
// Testbench of the temperature sensor control block
`timescale 1ns/1ps
module tsac_ctrl_tb;
  localparam [31:0] P0 = 32'h190, P1 = 32'h12C, P2 = 32'hC8, P3 = 32'h64;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, convDone = 1'b0, e, ack;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [12:0] convResult = 13'h0;
  logic [4:0] convCnt = 5'h0;
  logic [31:0] perTab [4] = '{P0, P1, P2, P3};
  logic [7:0] twBytes [3] = '{8'h90, 8'h03, 8'h12};
  wire [31:0] prdata;
  wire pready, pslverr, sdaOut, sdaOe, hsMode, convStart, converting, alertOut;
  wire sclLine, sdaLow;
  wire sdaWire = ~sdaLow & (sdaOe ? sdaOut : 1'b1);
  integer errorCnt = 0, nCompared = 0, n;
  always #10 sys_clk = ~sys_clk;
  tsac_ctrl #(.TIMEOUT_CYC(32'hC8), .PER0_CYC(P0), .PER1_CYC(P1), .PER2_CYC(P2),
    .PER3_CYC(P3)) dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclIn(sclLine), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .hsMode(hsMode), .devAddrSel(2'h0), .convDone(convDone),
    .convResult(convResult), .convStart(convStart), .converting(converting),
    .alertOut(alertOut));
  tsac_bus_master bm (.sclLine(sclLine), .sdaLow(sdaLow), .sdaWire(sdaWire));
  // Converter model: result 20 cycles after each start
  always @(posedge sys_clk) begin
    convDone <= 1'b0;
    if (convStart) convCnt <= 5'h14;
    else if (convCnt != 5'h0) begin
      convCnt <= convCnt - 5'h1;
      convDone <= (convCnt == 5'h1);
    end
  end
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    nCompared++;
    if (got !== ex) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task waitConv(input integer k);
    repeat (k) begin
      @(posedge sys_clk);
      while (convDone !== 1'b1) @(posedge sys_clk);
    end
    repeat (3) @(posedge sys_clk);
  endtask
  task waitStart;
    @(posedge sys_clk);
    while (convStart !== 1'b1) @(posedge sys_clk);
  endtask
  task alertIs(input logic ex);
    repeat (2) @(posedge sys_clk);
    chk("alert", {31'h0, ex}, {31'h0, alertOut});
  endtask
  task finish_test;
    if (errorCnt == 0 && nCompared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #1000000;
    errorCnt++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    apb(12'h004, 1'b0, 32'h0); chk("cfg", 32'h60A0, rd);
    apb(12'h008, 1'b0, 32'h0); chk("tlow", 32'h4B00, rd);
    apb(12'h00C, 1'b0, 32'h0); chk("thigh", 32'h5000, rd);
    apb(12'h006, 1'b0, 32'h0); chk("slverr", 32'h1, {31'h0, e});
    convResult <= 13'h1234;
    waitConv(1);
    apb(12'h000, 1'b0, 32'h0); chk("temp12", 32'h2340, rd);
    apb(12'h004, 1'b1, 32'h00B0);
    waitConv(1);
    apb(12'h000, 1'b0, 32'h0); chk("temp13", 32'h91A1, rd);
    for (int i = 0; i < 4; i++) begin
      apb(12'h004, 1'b1, {24'h0, i[1:0], 6'h00});
      waitStart;
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (convStart !== 1'b1);
      chk("period", perTab[i], n);
    end
    convResult <= 13'h008;
    apb(12'h008, 1'b1, 32'h0100);
    apb(12'h00C, 1'b1, 32'h0200);
    apb(12'h004, 1'b1, 32'h08C0);
    waitConv(1);
    convResult <= 13'h020;
    waitConv(1); alertIs(1'b1);
    waitConv(1); alertIs(1'b0);
    convResult <= 13'h018;
    waitConv(2); alertIs(1'b0);
    convResult <= 13'h008;
    waitConv(1); alertIs(1'b0);
    waitConv(1); alertIs(1'b1);
    // Interrupt mode, cleared by reading the result
    convResult <= 13'h030;
    apb(12'h004, 1'b1, 32'h02C0);
    waitConv(1); alertIs(1'b0);
    apb(12'h000, 1'b0, 32'h0); alertIs(1'b1);
    apb(12'h004, 1'b1, 32'h06C0); alertIs(1'b0);
    waitConv(1); alertIs(1'b1);
    // Shutdown after the running conversion, then one-shot
    waitStart;
    apb(12'h004, 1'b1, 32'h01C0);
    waitConv(1);
    n = 0;
    repeat (300) begin
      @(posedge sys_clk);
      if (convStart === 1'b1) n++;
    end
    chk("starts", 32'h0, n);
    apb(12'h004, 1'b0, 32'h0); chk("osdone", 32'h1, {31'h0, rd[15]});
    convResult <= 13'h050;
    apb(12'h004, 1'b1, 32'h81C0);
    apb(12'h004, 1'b0, 32'h0); chk("osbusy", 32'h0, {31'h0, rd[15]});
    waitConv(1);
    apb(12'h004, 1'b0, 32'h0); chk("osend", 32'h1, {31'h0, rd[15]});
    apb(12'h000, 1'b0, 32'h0); chk("ostemp", 32'h0500, rd);
    // Master code: no acknowledge, high speed until stop
    bm.busStart;
    bm.sendByte(8'h08, ack); chk("mcack", 32'h0, {31'h0, ack});
    chk("hs", 32'h1, {31'h0, hsMode});
    bm.busStop;
    repeat (8) @(posedge sys_clk);
    chk("hsoff", 32'h0, {31'h0, hsMode});
    apb(12'h00C, 1'b1, 32'h5070);
    bm.busStart;
    foreach (twBytes[k]) begin
      bm.sendByte(twBytes[k], ack); chk("ack", 32'h1, {31'h0, ack});
    end
    bm.busStop;
    apb(12'h00C, 1'b0, 32'h0); chk("msbonly", 32'h1270, rd);
    // Read ended by not-acknowledge, then a read stalled with the clock low
    bm.busStart;
    bm.sendByte(8'h91, ack);
    bm.sendByte(8'hFF, ack);
    repeat (4) @(posedge sys_clk); chk("nack", 32'h0, {31'h0, sdaOe});
    bm.busStop;
    bm.busStart;
    bm.sendByte(8'h91, ack);
    repeat (20) @(posedge sys_clk);
    chk("drive", 32'h1, {31'h0, sdaOe});
    repeat (250) @(posedge sys_clk);
    chk("release", 32'h0, {31'h0, sdaOe});
    bm.busStop;
    finish_test;
  end
endmodule
